// ---- vgo_pkg.sv ----
package vgo_pkg;
   localparam int CLK_NS = 25;
   localparam int SEP_UNIT_NS = 200;
   localparam int SEP_UNIT_CYC = (SEP_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CH_COUNT = 3;
   localparam int CH_RED = 0;
   localparam int CH_GREEN = 1;
   localparam int CH_BLUE = 2;
   localparam int GAIN_W = 7;
   localparam int OFF_W = 9;
   localparam int ABS_W = 7;
   localparam int REG_COUNT = 28;
   localparam int IDX_W = 5;
   localparam int PIN_COUNT = 6;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_FB = 5;
   localparam int MON_COUNT = 3;
   localparam int MON_BASE = 2;
   localparam int MON_HS = 0;
   localparam int MON_VS = 1;
   localparam int MON_SOG = 2;
   localparam int LVL_MSB = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] LVL_MAX = 8'hff;

   localparam logic [7:0] GAIN_ADDR [CH_COUNT] = '{8'h05, 8'h07, 8'h09};
   localparam logic [7:0] GAIN_COMMIT_ADDR [CH_COUNT] = '{8'h06, 8'h08, 8'h0a};
   localparam logic [7:0] OFF_HI_ADDR [CH_COUNT] = '{8'h0b, 8'h0d, 8'h0f};
   localparam logic [7:0] OFF_LO_ADDR [CH_COUNT] = '{8'h0c, 8'h0e, 8'h10};
   localparam logic [7:0] ADDR_THRESHOLD = 8'h11;
   localparam logic [7:0] ADDR_HSYNC_CTRL = 8'h12;
   localparam logic [7:0] ADDR_HSYNC_WIDTH = 8'h13;
   localparam logic [7:0] ADDR_VSYNC_CTRL = 8'h14;
   localparam logic [7:0] ADDR_AUTO_OFFSET = 8'h1b;
   localparam logic [7:0] GAIN_COMMIT_CODE = 8'h00;

   localparam int SRC_OVR_BIT = 7;
   localparam int SRC_SEL_BIT = 6;
   localparam int POL_OVR_BIT = 5;
   localparam int POL_BIT = 4;
   localparam int OUT_POL_BIT = 3;
   localparam int AUTO_OFF_BIT = 5;
   localparam int OFF_LSB_BIT = 7;

   localparam logic [7:0] RST_GAIN = 8'h40;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h20;
   localparam logic [7:0] RST_HSYNC_CTRL = 8'h18;
   localparam logic [7:0] RST_HSYNC_WIDTH = 8'h20;
   localparam logic [7:0] RST_VSYNC_CTRL = 8'h18;

   function automatic logic reg_mapped(input logic [7:0] a);
      reg_mapped = (a >= GAIN_ADDR[CH_RED] && a <= ADDR_VSYNC_CTRL) ||
         (a == ADDR_AUTO_OFFSET);
   endfunction

   function automatic logic [REG_COUNT-1:0][7:0] build_reset();
      logic [REG_COUNT-1:0][7:0] r;
      r = '0;
      for (int c = 0; c < CH_COUNT; c++)
      begin
         r[GAIN_ADDR[c][IDX_W-1:0]] = RST_GAIN;
         r[OFF_HI_ADDR[c][IDX_W-1:0]] = RST_OFFSET;
      end
      r[ADDR_THRESHOLD[IDX_W-1:0]] = RST_THRESHOLD;
      r[ADDR_HSYNC_CTRL[IDX_W-1:0]] = RST_HSYNC_CTRL;
      r[ADDR_HSYNC_WIDTH[IDX_W-1:0]] = RST_HSYNC_WIDTH;
      r[ADDR_VSYNC_CTRL[IDX_W-1:0]] = RST_VSYNC_CTRL;
      return r;
   endfunction

   localparam logic [REG_COUNT-1:0][7:0] REG_RESET = build_reset();

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_DEV = 9'h002,
      ST_AACK = 9'h004,
      ST_REG = 9'h008,
      ST_RACK = 9'h010,
      ST_WR = 9'h020,
      ST_WACK = 9'h040,
      ST_RD = 9'h080,
      ST_MACK = 9'h100
   } vgo_ser_st_t;
endpackage

// ---- vgo_sync_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface vgo_sync_if;
   logic [7:0] threshold;
   logic sep_in;
   logic sep_out;
   logic [7:0] hs_width;
   logic hs_trig;
   logic hs_out_pol;
   logic hs_out;
   modport ctrl(output threshold, sep_in, hs_width, hs_trig, hs_out_pol,
      input sep_out, hs_out);
   modport sep(input threshold, sep_in, output sep_out);
   modport gen(input hs_width, hs_trig, hs_out_pol, output hs_out);
endinterface
`default_nettype wire

// ---- vgo_sync_sep.sv ----
`timescale 1ns/10ps
`default_nettype none
module vgo_sync_sep #(
   parameter int UNIT_CYC = vgo_pkg::SEP_UNIT_CYC
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Sync pulse in, qualified pulse out.
   vgo_sync_if.sep sync
);
   import vgo_pkg::*;

   localparam logic [7:0] TICK_LAST = 8'(UNIT_CYC - 1);

   typedef struct packed {
      logic [7:0] tick;
      logic [7:0] units;
      logic pass;
   } vgo_sep_st_t;

   vgo_sep_st_t q;
   vgo_sep_st_t d;

   // The width is counted in fixed time units so that the threshold does
   // not move with the pixel rate.
   always_comb
   begin
      d = q;
      if (!sync.sep_in)
      begin
         d = '0;
      end
      else
      begin
         if (q.tick == TICK_LAST)
         begin
            d.tick = '0;
            if (q.units != LVL_MAX)
               d.units = 8'(q.units + 8'h01);
         end
         else
            d.tick = 8'(q.tick + 8'h01);
         d.pass = (q.units >= sync.threshold);
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= d;
   end

   assign sync.sep_out = q.pass;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_SEP_REJECT: assert property ($rose(q.pass) |->
      $past(q.units) >= $past(sync.threshold))
      else $error("separator passed a pulse below threshold");
   AST_SEP_DROP: assert property (!sync.sep_in |=> !sync.sep_out)
      else $error("separator output outlived its pulse");
endmodule
`default_nettype wire

// ---- vgo_hs_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module vgo_hs_gen (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Trigger, width and polarity in, pulse out.
   vgo_sync_if.gen sync
);
   import vgo_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic act;
      logic out;
   } vgo_gen_st_t;

   vgo_gen_st_t q;
   vgo_gen_st_t d;

   // A new trigger restarts the pulse; a width of zero gives no pulse.
   always_comb
   begin
      d = q;
      if (sync.hs_trig && sync.hs_width != 8'h00)
         d.cnt = sync.hs_width;
      else if (q.cnt != 8'h00)
         d.cnt = 8'(q.cnt - 8'h01);
      d.act = (d.cnt != 8'h00);
      d.out = (d.act == sync.hs_out_pol);
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         q <= '0;
      else
         q <= d;
   end

   assign sync.hs_out = q.out;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_HS_HOLD: assert property ((q.cnt > 8'h01 && !sync.hs_trig) |=>
      q.act && q.out == $past(sync.hs_out_pol))
      else $error("hsync pulse ended early");
   AST_HS_END: assert property ((q.cnt == 8'h01 && !sync.hs_trig) |=>
      !q.act ##1 !q.act || $past(sync.hs_trig))
      else $error("hsync pulse ran past its width");
endmodule
`default_nettype wire

// ---- vgo_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Green, blue gain apply after zero commit write.
// - Red offset high byte waits for low write.
// - Green, blue offsets likewise wait for low write.
// - Auto off: seven bits, signed absolute offset.
// - Auto on: full nine bits are target.
// - One offset step equals one output code.
// - Separator threshold is units of 200 ns.
// - Hsync source override or both sources active: select bit; otherwise device chooses.
// - Hsync select: pin or sync on green.
// - Hsync polarity override, otherwise auto detected.
// - Override polarity bit: one is active high.
// - Hsync output polarity bit, reset active high.
// - Hsync output lasts width count pixel clocks.
// - Vsync source override, otherwise device chooses.
// - Vsync select: pin or separator output.
// - Vsync polarity override, otherwise auto detected.
// - Vsync override polarity bit, reset active high.
// - Red gain applies after zero commit write.
module vgo_ctrl #(
   parameter logic [6:0] DEV_ADDR = 7'h4c,
   parameter logic [15:0] ACT_TIMEOUT_CYC = 16'hffff
) (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst,
   // Two-wire serial control pins.
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Sync pins.
   input wire logic i_hsync_pin,
   input wire logic i_vsync_pin,
   input wire logic i_sync_on_green_input,
   input wire logic i_pll_fb_event,
   // Active gains and offsets.
   output logic [vgo_pkg::GAIN_W-1:0] o_red_gain,
   output logic [vgo_pkg::GAIN_W-1:0] o_green_gain,
   output logic [vgo_pkg::GAIN_W-1:0] o_blue_gain,
   output logic [vgo_pkg::OFF_W-1:0] o_red_offset,
   output logic [vgo_pkg::OFF_W-1:0] o_green_offset,
   output logic [vgo_pkg::OFF_W-1:0] o_blue_offset,
   output logic o_auto_offset,
   // Processed syncs.
   output logic o_hsync_proc,
   output logic o_vsync_proc,
   output logic o_hsync_from_sog,
   output logic o_vsync_from_sep,
   output logic o_hsync_out
);
   import vgo_pkg::*;

   typedef struct packed {
      logic [PIN_COUNT-1:0] s1;
      logic [PIN_COUNT-1:0] s2;
      logic [PIN_COUNT-1:0] s3;
      vgo_ser_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic oe;
      logic nack;
      logic [REG_COUNT-1:0][7:0] regs;
      logic [CH_COUNT-1:0][GAIN_W-1:0] gain;
      logic [CH_COUNT-1:0][OFF_W-1:0] off;
      logic [CH_COUNT-1:0][OFF_W-1:0] eff;
      logic [MON_COUNT-1:0][15:0] idle;
      logic [MON_COUNT-1:0][7:0] lvl;
      logic hs_proc;
      logic vs_proc;
      logic use_sog;
      logic use_sep;
   } vgo_ctrl_st_t;

   vgo_ctrl_st_t q;
   vgo_ctrl_st_t d;

   vgo_sync_if sync_bus();

   logic start;
   logic stop;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_byte;
   logic [MON_COUNT-1:0] mon_active;
   logic [MON_COUNT-1:0] mon_pol_high;
   logic hs_pol;
   logic vs_pol;
   logic [7:0] hctl;
   logic [7:0] vctl;

   assign sda = q.s2[PIN_SDA];
   assign scl_rise = q.s2[PIN_SCL] && !q.s3[PIN_SCL];
   assign scl_fall = !q.s2[PIN_SCL] && q.s3[PIN_SCL];
   assign start = q.s2[PIN_SCL] && q.s3[PIN_SCL] && !sda && q.s3[PIN_SDA];
   assign stop = q.s2[PIN_SCL] && q.s3[PIN_SCL] && sda && !q.s3[PIN_SDA];
   assign rd_byte = reg_mapped(q.ptr) ? q.regs[q.ptr[IDX_W-1:0]] : 8'h00;
   assign hctl = q.regs[ADDR_HSYNC_CTRL[IDX_W-1:0]];
   assign vctl = q.regs[ADDR_VSYNC_CTRL[IDX_W-1:0]];

   // Activity is an edge seen within the timeout; polarity is taken as
   // the rarer level, since a sync pulse is short against its period.
   genvar m;
   generate
      for (m = 0; m < MON_COUNT; m++)
      begin : g_mon
         assign mon_active[m] = (q.idle[m] < ACT_TIMEOUT_CYC);
         assign mon_pol_high[m] = !q.lvl[m][LVL_MSB];
      end
   endgenerate

   assign hs_pol = hctl[POL_OVR_BIT] ? hctl[POL_BIT] :
      (q.use_sog ? mon_pol_high[MON_SOG] : mon_pol_high[MON_HS]);
   assign vs_pol = vctl[POL_OVR_BIT] ? vctl[POL_BIT] :
      mon_pol_high[MON_VS];

   always_comb
   begin
      d = q;
      wr_en = 1'b0;
      wr_addr = q.ptr;
      wr_data = q.sh;
      d.s1 = {i_pll_fb_event, i_sync_on_green_input, i_vsync_pin,
         i_hsync_pin, i_sda, i_scl};
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (start)
      begin
         d.st = ST_DEV;
         d.cnt = 4'h0;
         d.oe = 1'b0;
      end
      else if (stop)
      begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
      end
      else if (scl_rise)
      begin
         if (q.st inside {ST_DEV, ST_REG, ST_WR})
         begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = 4'(q.cnt + 4'h1);
         end
         else if (q.st == ST_RD)
            d.cnt = 4'(q.cnt + 4'h1);
         else if (q.st == ST_MACK)
            d.nack = sda;
      end
      else if (scl_fall)
      begin
         unique case (q.st)
            ST_IDLE:
               d.oe = 1'b0;
            ST_DEV:
               if (q.cnt == BITS_PER_BYTE)
               begin
                  d.rw = q.sh[0];
                  d.oe = (q.sh[7:1] == DEV_ADDR);
                  d.st = (q.sh[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
               end
            ST_AACK:
            begin
               d.cnt = 4'h0;
               if (q.rw)
               begin
                  d.st = ST_RD;
                  d.sh = rd_byte;
                  d.oe = !rd_byte[7];
                  d.ptr = 8'(q.ptr + 8'h01);
               end
               else
               begin
                  d.st = ST_REG;
                  d.oe = 1'b0;
               end
            end
            ST_REG:
               if (q.cnt == BITS_PER_BYTE)
               begin
                  d.st = ST_RACK;
                  d.oe = 1'b1;
                  d.ptr = q.sh;
               end
            ST_WR:
               if (q.cnt == BITS_PER_BYTE)
               begin
                  d.st = ST_WACK;
                  d.oe = 1'b1;
                  wr_en = 1'b1;
                  d.ptr = 8'(q.ptr + 8'h01);
               end
            ST_RACK, ST_WACK:
            begin
               d.st = ST_WR;
               d.oe = 1'b0;
               d.cnt = 4'h0;
            end
            ST_RD:
               if (q.cnt == BITS_PER_BYTE)
               begin
                  d.st = ST_MACK;
                  d.oe = 1'b0;
                  d.nack = 1'b1;
               end
               else
               begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.oe = !q.sh[6];
               end
            ST_MACK:
               if (q.nack)
                  d.st = ST_IDLE;
               else
               begin
                  d.st = ST_RD;
                  d.cnt = 4'h0;
                  d.sh = rd_byte;
                  d.oe = !rd_byte[7];
                  d.ptr = 8'(q.ptr + 8'h01);
               end
            default:
            begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end

      // Writes to unmapped addresses are dropped; reads of them give zero.
      if (wr_en && reg_mapped(wr_addr))
         d.regs[wr_addr[IDX_W-1:0]] = wr_data;

      // Commits copy a whole staged value at once, so the datapath never
      // sees a half-written gain or offset.
      for (int c = 0; c < CH_COUNT; c++)
      begin
         if (wr_en && wr_addr == GAIN_COMMIT_ADDR[c] &&
            wr_data == GAIN_COMMIT_CODE)
            d.gain[c] = q.regs[GAIN_ADDR[c][IDX_W-1:0]][GAIN_W-1:0];
         if (wr_en && wr_addr == OFF_LO_ADDR[c])
            d.off[c] = {q.regs[OFF_HI_ADDR[c][IDX_W-1:0]],
               wr_data[OFF_LSB_BIT]};
         if (d.regs[ADDR_AUTO_OFFSET[IDX_W-1:0]][AUTO_OFF_BIT])
            d.eff[c] = d.off[c];
         else
            d.eff[c] = {{(OFF_W - ABS_W){d.off[c][ABS_W-1]}},
               d.off[c][ABS_W-1:0]};
      end

      for (int k = 0; k < MON_COUNT; k++)
      begin
         if (q.s2[MON_BASE + k] != q.s3[MON_BASE + k])
            d.idle[k] = 16'h0000;
         else if (q.idle[k] < ACT_TIMEOUT_CYC)
            d.idle[k] = 16'(q.idle[k] + 16'h0001);
         if (q.s2[MON_BASE + k] && q.lvl[k] != LVL_MAX)
            d.lvl[k] = 8'(q.lvl[k] + 8'h01);
         else if (!q.s2[MON_BASE + k] && q.lvl[k] != 8'h00)
            d.lvl[k] = 8'(q.lvl[k] - 8'h01);
      end

      if (hctl[SRC_OVR_BIT] || (mon_active[MON_HS] && mon_active[MON_SOG]))
         d.use_sog = hctl[SRC_SEL_BIT];
      else
         d.use_sog = !mon_active[MON_HS] && mon_active[MON_SOG];
      d.hs_proc = (q.use_sog ? q.s2[MON_BASE + MON_SOG] :
         q.s2[MON_BASE + MON_HS]) == hs_pol;
      d.use_sep = vctl[SRC_OVR_BIT] ? vctl[SRC_SEL_BIT] :
         !mon_active[MON_VS];
      d.vs_proc = q.use_sep ? sync_bus.sep_out :
         (q.s2[MON_BASE + MON_VS] == vs_pol);
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.regs <= REG_RESET;
         q.gain <= {CH_COUNT{RST_GAIN[GAIN_W-1:0]}};
         q.idle <= '1;
      end
      else
         q <= d;
   end

   assign sync_bus.threshold = q.regs[ADDR_THRESHOLD[IDX_W-1:0]];
   assign sync_bus.sep_in = (q.s2[MON_BASE + MON_SOG] ==
      mon_pol_high[MON_SOG]);
   assign sync_bus.hs_width = q.regs[ADDR_HSYNC_WIDTH[IDX_W-1:0]];
   assign sync_bus.hs_trig = q.s2[PIN_FB] && !q.s3[PIN_FB];
   assign sync_bus.hs_out_pol = hctl[OUT_POL_BIT];

   vgo_sync_sep u_sep (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .sync(sync_bus)
   );

   vgo_hs_gen u_gen (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .sync(sync_bus)
   );

   assign o_sda_out = 1'b0;
   assign o_sda_oe = q.oe;
   assign o_red_gain = q.gain[CH_RED];
   assign o_green_gain = q.gain[CH_GREEN];
   assign o_blue_gain = q.gain[CH_BLUE];
   assign o_red_offset = q.eff[CH_RED];
   assign o_green_offset = q.eff[CH_GREEN];
   assign o_blue_offset = q.eff[CH_BLUE];
   assign o_auto_offset = q.regs[ADDR_AUTO_OFFSET[IDX_W-1:0]][AUTO_OFF_BIT];
   assign o_hsync_proc = q.hs_proc;
   assign o_vsync_proc = q.vs_proc;
   assign o_hsync_from_sog = q.use_sog;
   assign o_vsync_from_sep = q.use_sep;
   assign o_hsync_out = sync_bus.hs_out;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_green_commit;
      wr_en && wr_addr == GAIN_COMMIT_ADDR[CH_GREEN] &&
         wr_data == GAIN_COMMIT_CODE;
   endsequence
   sequence s_blue_stage;
      wr_en && wr_addr == GAIN_ADDR[CH_BLUE];
   endsequence

   AST_GAIN_COMMIT: assert property (s_green_commit |=>
      q.gain[CH_GREEN] == $past(q.regs[GAIN_ADDR[CH_GREEN][IDX_W-1:0]][6:0]))
      else $error("green gain not applied on commit");
   AST_GAIN_HOLD: assert property (s_blue_stage |=>
      $stable(q.gain[CH_BLUE]))
      else $error("blue gain applied without commit");
   AST_OFF_HOLD: assert property ((wr_en &&
      wr_addr == OFF_HI_ADDR[CH_RED]) |=> $stable(q.off[CH_RED]))
      else $error("red offset applied before low write");
   AST_OFF_APPLY: assert property ((wr_en &&
      wr_addr == OFF_LO_ADDR[CH_BLUE]) |=> q.off[CH_BLUE] ==
      {$past(q.regs[OFF_HI_ADDR[CH_BLUE][IDX_W-1:0]]),
      $past(wr_data[OFF_LSB_BIT])})
      else $error("blue offset not applied on low write");
   AST_OFF_ABS: assert property (!o_auto_offset |->
      q.eff[CH_GREEN] == {{2{q.off[CH_GREEN][6]}}, q.off[CH_GREEN][6:0]})
      else $error("absolute offset not sign extended");
   AST_HS_OVR: assert property ((hctl[SRC_OVR_BIT] &&
      hctl[SRC_SEL_BIT]) |=> q.use_sog)
      else $error("hsync source override ignored");
   AST_VS_SEP: assert property ((q.use_sep && $stable(q.use_sep)) |=>
      q.vs_proc == $past(sync_bus.sep_out))
      else $error("vsync not taken from separator");
endmodule
`default_nettype wire

// ---- vgo_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module vgo_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h4c
) (
   // Clock and resolved data wire.
   input wire logic i_clock,
   input wire logic i_sda,
   // Serial clock, and a pull-down on the data wire.
   output var logic o_scl,
   output var logic o_sda_low
);
   int nacks = 0;

   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   // Data moves only two cycles into the ten cycle low phase, so no stray start or stop is seen.
   task automatic bitx(input logic b, output logic r);
      cyc(2);
      o_sda_low = ~b;
      cyc(8);
      o_scl = 1'b1;
      cyc(10);
      r = i_sda;
      o_scl = 1'b0;
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
      input logic ack_in, output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bitx(tx[i], rx[i]);
      bitx(ack_in, ack_out);
   endtask

   task automatic snd(input logic [7:0] tx);
      logic [7:0] rx;
      logic ak;
      xfer(tx, rx, 1'b1, ak);
      nacks += (ak !== 1'b0);
   endtask

   task automatic start();
      cyc(2);
      o_sda_low = 1'b0;
      cyc(8);
      o_scl = 1'b1;
      cyc(10);
      o_sda_low = 1'b1;
      cyc(10);
      o_scl = 1'b0;
   endtask

   task automatic stop();
      cyc(2);
      o_sda_low = 1'b1;
      cyc(8);
      o_scl = 1'b1;
      cyc(10);
      o_sda_low = 1'b0;
      cyc(10);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      snd({DEV_ADDR, 1'b0});
      snd(a);
      snd(d);
      stop();
   endtask

   // The last byte gets no acknowledge, which ends the read.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic ak;
      start();
      snd({DEV_ADDR, 1'b0});
      snd(a);
      start();
      snd({DEV_ADDR, 1'b1});
      xfer(8'hff, d, 1'b1, ak);
      stop();
   endtask
endmodule
`default_nettype wire

// ---- tb_video_gain_offset_sync_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_video_gain_offset_sync_ctrl;
   import vgo_pkg::*;
   localparam int TMO = 60000;
   localparam logic [7:0] RA [6] = '{ADDR_THRESHOLD, ADDR_HSYNC_CTRL,
      ADDR_VSYNC_CTRL, ADDR_HSYNC_WIDTH, 8'h15, 8'h20};
   localparam logic [7:0] RV [6] = '{8'h20, 8'h18, 8'h18, 8'h20, 8'h00,
      8'h00};
   // Fields: address, value, pin level, source, processed, check it.
   localparam logic [19:0] SEL [9] = '{{8'h12, 8'ha0, 4'b0011},
      {8'h12, 8'hb0, 4'b0001}, {8'h12, 8'he0, 4'b0111},
      {8'h12, 8'hf0, 4'b1111}, {8'h12, 8'h00, 4'b1001},
      {8'h14, 8'h00, 4'b1101}, {8'h14, 8'ha0, 4'b0011},
      {8'h14, 8'hb0, 4'b1011}, {8'h14, 8'hc0, 4'b0100}};
   logic i_clock, i_rst, scl, sda_low, sda_oe, sda_out, sda_w;
   logic hs, vs, sync_on_green_input, fb, auto_off, hproc, vproc, hsrc, vsrc, hout;
   logic [6:0] gain [3];
   logic [8:0] offs [3];
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   assign sda_w = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

   vgo_host_model u_host (.i_clock(i_clock),
      .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

   vgo_ctrl #(.ACT_TIMEOUT_CYC(16'h0040)) u_vgo_ctrl (
      .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w),
      .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_hsync_pin(hs),
      .i_vsync_pin(vs), .i_sync_on_green_input(sync_on_green_input), .i_pll_fb_event(fb),
      .o_red_gain(gain[0]), .o_green_gain(gain[1]), .o_blue_gain(gain[2]),
      .o_red_offset(offs[0]), .o_green_offset(offs[1]),
      .o_blue_offset(offs[2]), .o_auto_offset(auto_off),
      .o_hsync_proc(hproc), .o_vsync_proc(vproc), .o_hsync_from_sog(hsrc),
      .o_vsync_from_sep(vsrc), .o_hsync_out(hout));

   initial
   begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Auto off keeps only seven bits, read as a signed step count.
   function automatic logic [8:0] exp_off(input logic [7:0] h,
      input logic [7:0] l, input logic auto_on);
      return auto_on ? {h, l[7]} : {{2{h[5]}}, h[5:0], l[7]};
   endfunction

   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == TMO)
      begin
         miscompares++;
         end_sim();
      end
   end

   initial
   begin
      logic [7:0] d, v;
      logic [7:0] his [3];
      logic [7:0] los [3];
      int n;
      logic s;
      void'($urandom(32'h1f64));
      {i_rst, hs, vs, sync_on_green_input, fb} = 5'b10000;
      repeat (6) @(posedge i_clock);
      #1;
      i_rst = 1'b0;
      u_host.cyc(6);
      foreach (RA[i])
      begin
         u_host.rd(RA[i], d);
         chk(d, RV[i]);
      end
      for (int c = 0; c < 3; c++)
      begin
         chk(offs[c], 9'h000);
         {hs, vs} = 2'($urandom);
         v = 8'h41 + 8'($urandom_range(0, 62));
         u_host.wr(GAIN_ADDR[c], v);
         chk(gain[c], 7'h40);
         u_host.wr(GAIN_COMMIT_ADDR[c], 8'h01);
         chk(gain[c], 7'h40);
         u_host.wr(GAIN_COMMIT_ADDR[c], GAIN_COMMIT_CODE);
         chk(gain[c], v[6:0]);
      end
      u_host.wr(ADDR_AUTO_OFFSET, 8'h20);
      chk(auto_off, 1'b1);
      for (int c = 0; c < 3; c++)
      begin
         his[c] = 8'($urandom) | 8'h01;
         los[c] = 8'($urandom);
         u_host.wr(OFF_HI_ADDR[c], his[c]);
         chk(offs[c], 9'h000);
         u_host.wr(OFF_LO_ADDR[c], los[c]);
         chk(offs[c], exp_off(his[c], los[c], 1'b1));
      end
      u_host.wr(ADDR_AUTO_OFFSET, 8'h00);
      for (int c = 0; c < 3; c++)
         chk(offs[c], exp_off(his[c], los[c], 1'b0));
      for (int k = 0; k < 2; k++)
      begin
         v = (k != 0) ? 8'hff : 8'($urandom_range(1, 40));
         u_host.wr(ADDR_HSYNC_WIDTH, v);
         u_host.wr(ADDR_HSYNC_CTRL, (k != 0) ? 8'h10 : 8'h18);
         fb = 1'b1;
         u_host.cyc(2);
         fb = 1'b0;
         n = 0;
         repeat (300)
         begin
            u_host.cyc(1);
            n += (hout === (k == 0));
         end
         chk(16'(n), {8'h00, v});
      end
      foreach (SEL[i])
      begin
         {hs, vs, sync_on_green_input} = {3{SEL[i][3]}};
         u_host.wr(SEL[i][19:12], SEL[i][11:4]);
         s = (SEL[i][19:12] == ADDR_HSYNC_CTRL);
         chk(s ? hsrc : vsrc, SEL[i][2]);
         if (SEL[i][0])
            chk(s ? hproc : vproc, SEL[i][1]);
      end
      // Two units of 200 ns make a 16 clock threshold at this rate.
      u_host.wr(ADDR_THRESHOLD, 8'h02);
      u_host.rd(ADDR_THRESHOLD, d);
      chk(d, 8'h02);
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         for (int j = 0; j < 60; j++)
         begin
            sync_on_green_input = (j < ((k != 0) ? 24 : 12));
            u_host.cyc(1);
            n += (vproc === 1'b1);
         end
         chk(n != 0, k != 0);
      end
      chk(16'(u_host.nacks), 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
